/* rtl/cpu_flag_defs.vh */
`ifndef CPU_FLAG_DEFS_VH
`define CPU_FLAG_DEFS_VH

// Register port map
`define PF_ADDR_W         4
`define PF_ADDR_FLAGS     4'h0
`define PF_ADDR_HSP       4'h1
`define PF_ADDR_TSP       4'h2
`define PF_ADDR_ACTSP     4'h3
`define PF_ADDR_STATUS    4'h4

// Flag field positions
`define PF_BIT_C          0
`define PF_BIT_D          1
`define PF_BIT_Z          2
`define PF_BIT_S          3
`define PF_BIT_B          4
`define PF_BIT_O          5
`define PF_BIT_I          6
`define PF_BIT_U          7
`define PF_PRI_LSB        8
`define PF_PRI_MSB        10
`define PF_WIDTH          11

// Reset values
`define PF_FLAGS_RESET    11'h000
`define PF_SP_RESET       16'h0000
`define PF_LEVEL_RESET    3'h0
`define PF_RDATA_RESET    16'h0000

// Fill above the flags and above the status bits on reads
`define PF_UPPER_ZERO     5'h00
`define PF_STATUS_ZERO    14'h0000

// Trap vectors that switch to the handler stack
`define PF_TRAP_U_CLR_MAX 6'h1F

`endif

/* rtl/irq_accept.v */
`timescale 1ns/1ps
// Decides whether a pending interrupt may be taken
module irq_accept
(
    // Request
    input  wire       req_valid_i,
    input  wire [2:0] req_level_i,
    // Current state
    input  wire       int_enable_i,
    input  wire [2:0] cpu_priority_level_i,
    // Result
    output wire       accept_o
);

    assign accept_o = req_valid_i & int_enable_i & (req_level_i > cpu_priority_level_i);

endmodule

/* rtl/cpu_flag_register.v */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cpu_flag_defs.vh"
module cpu_flag_register
#(
    parameter SP_W = 16
)
(
    // Clock and reset
    input  wire                 clk_i,
    input  wire                 srst_i,
    // Register port
    input  wire [`PF_ADDR_W-1:0] addr_i,
    input  wire [15:0]          wdata_i,
    input  wire                 wr_i,
    input  wire                 rd_i,
    output reg  [15:0]          rdata_o,
    // ALU results, each with its own update enable
    input  wire                 alu_c_we_i,
    input  wire                 alu_c_i,
    input  wire                 alu_z_we_i,
    input  wire                 alu_s_we_i,
    input  wire [15:0]          alu_result_i,
    input  wire                 alu_byte_i,
    input  wire                 alu_o_we_i,
    input  wire                 alu_o_i,
    // Core-side stack pointer writes
    input  wire                 sp_we_i,
    input  wire [SP_W-1:0]      sp_wdata_i,
    // Interrupt request and trap
    input  wire                 irq_valid_i,
    input  wire [2:0]           irq_level_i,
    input  wire                 trap_exec_i,
    input  wire [5:0]           trap_vector_i,
    // Core-facing state
    output reg                  irq_ack_o,
    output reg                  bank_sel_o,
    output reg  [SP_W-1:0]      active_sp_o,
    output reg  [2:0]           cpu_priority_level_o,
    output reg  [`PF_WIDTH-1:0] processor_flags_o
);

    // Flag state and its next value
    reg  [`PF_WIDTH-1:0] processor_flags_reg;
    reg  [`PF_WIDTH-1:0] processor_flags_next;
    // Stack pointers and their next values
    reg  [SP_W-1:0]      handler_stack_ptr_reg;
    reg  [SP_W-1:0]      handler_stack_ptr_next;
    reg  [SP_W-1:0]      task_stack_ptr_reg;
    reg  [SP_W-1:0]      task_stack_ptr_next;
    // Read data for the cycle after a read strobe
    reg  [15:0]          rdata_next;
    // Decoded conditions
    wire                 accept;
    wire                 result_zero;
    wire                 result_neg;
    wire                 trap_low;
    wire                 use_task_sp;
    wire                 sw_flag_wr;
    wire                 sw_hsp_wr;
    wire                 sw_tsp_wr;
    wire                 core_hsp_wr;
    wire                 core_tsp_wr;

    // Pointer selected by a given stack flag
    function [SP_W-1:0] pick_sp;
        input            u;
        input [SP_W-1:0] hsp;
        input [SP_W-1:0] tsp;
        begin
            pick_sp = u ? tsp : hsp;
        end
    endfunction

    // Register port write aimed at one address
    function port_wr;
        input                  we;
        input [`PF_ADDR_W-1:0] a;
        input [`PF_ADDR_W-1:0] target;
        begin
            port_wr = we & (a == target);
        end
    endfunction

    // All-zero test of a result, byte or word wide
    function is_zero;
        input        byte_op;
        input [15:0] value;
        begin
            if (byte_op)
                is_zero = (value[7:0] == 8'h00);
            else
                is_zero = (value == 16'h0000);
        end
    endfunction

    // Sign bit of a result, byte or word wide
    function sign_of;
        input        byte_op;
        input [15:0] value;
        begin
            sign_of = byte_op ? value[7] : value[15];
        end
    endfunction

    // Interrupt acceptance check
    irq_accept u_accept
    (
        .req_valid_i          (irq_valid_i),
        .req_level_i          (irq_level_i),
        .int_enable_i         (processor_flags_reg[`PF_BIT_I]),
        .cpu_priority_level_i (processor_flags_reg[`PF_PRI_MSB:`PF_PRI_LSB]),
        .accept_o             (accept)
    );

    // Result decode, byte or word width
    assign result_zero = is_zero(alu_byte_i, alu_result_i);
    assign result_neg  = sign_of(alu_byte_i, alu_result_i);

    assign trap_low    = trap_exec_i & (trap_vector_i <= `PF_TRAP_U_CLR_MAX);

    // Register port write decode
    assign sw_flag_wr  = port_wr(wr_i, addr_i, `PF_ADDR_FLAGS);
    assign sw_hsp_wr   = port_wr(wr_i, addr_i, `PF_ADDR_HSP);
    assign sw_tsp_wr   = port_wr(wr_i, addr_i, `PF_ADDR_TSP);

    assign use_task_sp = processor_flags_reg[`PF_BIT_U];
    assign core_hsp_wr = sp_we_i & ~use_task_sp;
    assign core_tsp_wr = sp_we_i & use_task_sp;

    // Next flag value; ALU and acknowledge take priority over software
    always @*
    begin
        processor_flags_next = processor_flags_reg;
        if (sw_flag_wr)
        begin
            processor_flags_next = wdata_i[`PF_WIDTH-1:0];
        end
        if (alu_c_we_i)
        begin
            processor_flags_next[`PF_BIT_C] = alu_c_i;
        end
        if (alu_z_we_i)
        begin
            processor_flags_next[`PF_BIT_Z] = result_zero;
        end
        if (alu_s_we_i)
        begin
            processor_flags_next[`PF_BIT_S] = result_neg;
        end
        if (alu_o_we_i)
        begin
            processor_flags_next[`PF_BIT_O] = alu_o_i;
        end
        if (accept)
        begin
            processor_flags_next[`PF_BIT_I] = 1'h0;
        end
        if (accept || trap_low)
        begin
            processor_flags_next[`PF_BIT_U] = 1'h0;
        end
    end

    // Flag register
    always @(posedge clk_i)
    begin
        if (srst_i)
            processor_flags_reg <= `PF_FLAGS_RESET;
        else
            processor_flags_reg <= processor_flags_next;
    end

    // Next pointer values; a core write wins over a port write
    always @*
    begin
        handler_stack_ptr_next = handler_stack_ptr_reg;
        task_stack_ptr_next    = task_stack_ptr_reg;
        if (core_hsp_wr)
        begin
            handler_stack_ptr_next = sp_wdata_i;
        end
        else if (sw_hsp_wr)
        begin
            handler_stack_ptr_next = wdata_i[SP_W-1:0];
        end
        if (core_tsp_wr)
        begin
            task_stack_ptr_next = sp_wdata_i;
        end
        else if (sw_tsp_wr)
        begin
            task_stack_ptr_next = wdata_i[SP_W-1:0];
        end
    end

    // Stack pointer registers
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            handler_stack_ptr_reg <= `PF_SP_RESET;
            task_stack_ptr_reg    <= `PF_SP_RESET;
        end
        else
        begin
            handler_stack_ptr_reg <= handler_stack_ptr_next;
            task_stack_ptr_reg    <= task_stack_ptr_next;
        end
    end

    // Registered core outputs show the state after this edge
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_ack_o            <= 1'h0;
            bank_sel_o           <= 1'h0;
            active_sp_o          <= `PF_SP_RESET;
            cpu_priority_level_o <= `PF_LEVEL_RESET;
            processor_flags_o    <= `PF_FLAGS_RESET;
        end
        else
        begin
            irq_ack_o            <= accept;
            bank_sel_o           <= processor_flags_next[`PF_BIT_B];
            cpu_priority_level_o <= processor_flags_next[`PF_PRI_MSB:`PF_PRI_LSB];
            processor_flags_o    <= processor_flags_next;
            active_sp_o          <= pick_sp(processor_flags_next[`PF_BIT_U],
                                            handler_stack_ptr_next,
                                            task_stack_ptr_next);
        end
    end

    // Read data selection; unmapped addresses and idle cycles read zero
    always @*
    begin
        rdata_next = `PF_RDATA_RESET;
        if (rd_i)
        begin
            case (addr_i)
                `PF_ADDR_FLAGS:
                begin
                    rdata_next = {`PF_UPPER_ZERO, processor_flags_reg};
                end
                `PF_ADDR_HSP:
                begin
                    rdata_next = handler_stack_ptr_reg;
                end
                `PF_ADDR_TSP:
                begin
                    rdata_next = task_stack_ptr_reg;
                end
                `PF_ADDR_ACTSP:
                begin
                    rdata_next = pick_sp(use_task_sp, handler_stack_ptr_reg,
                                         task_stack_ptr_reg);
                end
                `PF_ADDR_STATUS:
                begin
                    rdata_next = {`PF_STATUS_ZERO, irq_ack_o, accept};
                end
                default:
                begin
                    rdata_next = `PF_RDATA_RESET;
                end
            endcase
        end
    end

    // Read data register, valid in the cycle after the strobe only
    always @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= `PF_RDATA_RESET;
        else
            rdata_o <= rdata_next;
    end

endmodule

/* test/cpu_flag_register_asserts.sv */
`timescale 1ns/1ps
// Port-level checks of the flag register
module cpu_flag_register_chk
(
    // Clock, reset and strobes
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    // ALU and interrupt side
    input wire logic        alu_c_we_i,
    input wire logic        alu_c_i,
    input wire logic        alu_z_we_i,
    input wire logic        alu_s_we_i,
    input wire logic        alu_byte_i,
    input wire logic [15:0] alu_result_i,
    input wire logic        irq_valid_i,
    input wire logic [2:0]  irq_level_i,
    input wire logic        trap_exec_i,
    input wire logic [5:0]  trap_vector_i,
    // Outputs watched
    input wire logic        irq_ack_o,
    input wire logic [15:0] rdata_o,
    input wire logic [2:0]  cpu_priority_level_o,
    input wire logic [10:0] processor_flags_o
);
    // Interrupt enable bit
    wire ien = processor_flags_o[6];
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_carry_take:
        assert property (alu_c_we_i |=> processor_flags_o[0] == $past(alu_c_i))
        else $error("carry flag wrong");
    chk_zero_word:
        assert property (alu_z_we_i && !alu_byte_i |=>
            processor_flags_o[2] == ($past(alu_result_i) == 16'h0000))
        else $error("zero flag wrong");
    chk_sign_word:
        assert property (alu_s_we_i && !alu_byte_i |=>
            processor_flags_o[3] == ($past(alu_result_i) >= 16'h8000))
        else $error("sign flag wrong");
    chk_ack_clears:
        assert property (irq_ack_o |-> processor_flags_o[7:6] == 2'h0)
        else $error("ack left I or U set");
    chk_ack_cause:
        assert property (irq_ack_o |-> $past(irq_valid_i) && $past(ien)
            && $past(irq_level_i) > $past(cpu_priority_level_o))
        else $error("ack without cause");
    chk_trap_low:
        assert property (trap_exec_i && trap_vector_i < 6'h20 && !wr_i
            |=> !processor_flags_o[7])
        else $error("low trap kept U");
    chk_read_idle:
        assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside slot");
    chk_carry_hold:
        assert property (!alu_c_we_i && !wr_i |=> $stable(processor_flags_o[0]))
        else $error("carry changed unasked");
    chk_ack_single:
        assert property (irq_ack_o |=> !irq_ack_o)
        else $error("second ack without enable");
    chk_level_mirror:
        assert property (cpu_priority_level_o == processor_flags_o[10:8])
        else $error("level output differs from field");
endmodule

bind cpu_flag_register cpu_flag_register_chk i_chk (.clk_i, .srst_i, .wr_i, .rd_i,
    .alu_c_we_i, .alu_c_i, .alu_z_we_i, .alu_s_we_i, .alu_byte_i, .alu_result_i,
    .irq_valid_i, .irq_level_i, .trap_exec_i, .trap_vector_i, .irq_ack_o, .rdata_o,
    .cpu_priority_level_o, .processor_flags_o);

/* test/test_cpu_flag_register.sv */
`timescale 1ns/1ps
module test_cpu_flag_register;
    logic        clk_i, srst_i, wr_i, rd_i, alu_c_we_i, alu_c_i, alu_z_we_i;
    logic        alu_s_we_i, alu_byte_i, alu_o_we_i, alu_o_i, sp_we_i, irq_valid_i;
    logic        trap_exec_i, irq_ack_o, bank_sel_o;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i, alu_result_i, sp_wdata_i, rdata_o, active_sp_o;
    logic [5:0]  trap_vector_i;
    logic [2:0]  irq_level_i, cpu_priority_level_o;
    logic [10:0] processor_flags_o;
    int          failures;
    int          tests_run;
    cpu_flag_register i_dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .alu_c_we_i, .alu_c_i, .alu_z_we_i, .alu_s_we_i, .alu_result_i, .alu_byte_i,
        .alu_o_we_i, .alu_o_i, .sp_we_i, .sp_wdata_i, .irq_valid_i, .irq_level_i,
        .trap_exec_i, .trap_vector_i, .irq_ack_o, .bank_sel_o, .active_sp_o,
        .cpu_priority_level_o, .processor_flags_o);
    // Compare and count
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        chk("rdata", rdata_o, e);
    endtask
    // Raise a request, look at the ack in the cycle it stands, then drop it
    task irq(input logic [2:0] l, input logic [15:0] e);
        @(posedge clk_i);
        irq_valid_i <= 1'h1;
        irq_level_i <= l;
        @(posedge clk_i);
        #1;
        chk("ack", irq_ack_o, e);
        @(posedge clk_i);
        irq_valid_i <= 1'h0;
        #1;
    endtask
    task trap(input logic [5:0] v, input logic [15:0] e);
        wr(4'h0, 16'h0080);
        @(posedge clk_i);
        trap_exec_i <= 1'h1;
        trap_vector_i <= v;
        @(posedge clk_i);
        trap_exec_i <= 1'h0;
        #1;
        chk("trap", processor_flags_o, e);
    endtask
    task t_regs;
        rd(4'h0, 16'h0000);
        wr(4'h0, 16'h0550);
        rd(4'h0, 16'h0550);
        chk("bank", bank_sel_o, 16'h0001);
        chk("level", cpu_priority_level_o, 16'h0005);
        wr(4'h1, 16'hA5C3);
        wr(4'h2, 16'h3C5A);
        chk("sp", active_sp_o, 16'hA5C3);
        wr(4'h0, 16'h0080);
        rd(4'h3, 16'h3C5A);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        $display("regs done");
    endtask
    task t_alu;
        @(posedge clk_i);
        {alu_c_we_i, alu_c_i, alu_o_we_i, alu_o_i, alu_z_we_i, alu_s_we_i} <= 6'h3F;
        alu_result_i <= 16'h8000;
        @(posedge clk_i);
        {alu_c_we_i, alu_o_we_i, alu_z_we_i, alu_s_we_i} <= 4'h0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("flags", processor_flags_o, 16'h00A9);
        {alu_z_we_i, alu_s_we_i} <= 2'h3;
        alu_result_i <= 16'h0000;
        @(posedge clk_i);
        {alu_z_we_i, alu_s_we_i} <= 2'h0;
        #1;
        chk("zero", processor_flags_o, 16'h00A5);
        $display("alu done");
    endtask
    task t_irq;
        wr(4'h0, 16'h03C0);
        irq(3'h3, 16'h0000);
        irq(3'h4, 16'h0001);
        chk("ie", processor_flags_o, 16'h0300);
        irq(3'h7, 16'h0000);
        trap(6'h1F, 16'h0000);
        trap(6'h20, 16'h0080);
        $display("irq done");
    endtask
    // Core stack writes, byte-wide results and the status word
    task t_core;
        @(posedge clk_i);
        sp_we_i <= 1'h1;
        sp_wdata_i <= 16'h1234;
        @(posedge clk_i);
        sp_we_i <= 1'h0;
        #1;
        chk("task sp", active_sp_o, 16'h1234);
        rd(4'h2, 16'h1234);
        rd(4'h1, 16'hA5C3);
        wr(4'h0, 16'h0000);
        @(posedge clk_i);
        sp_we_i <= 1'h1;
        sp_wdata_i <= 16'h5678;
        @(posedge clk_i);
        sp_we_i <= 1'h0;
        #1;
        chk("handler sp", active_sp_o, 16'h5678);
        rd(4'h2, 16'h1234);
        @(posedge clk_i);
        {alu_byte_i, alu_z_we_i, alu_s_we_i} <= 3'h7;
        alu_result_i <= 16'h0180;
        @(posedge clk_i);
        {alu_byte_i, alu_z_we_i, alu_s_we_i} <= 3'h0;
        #1;
        chk("byte sign", processor_flags_o, 16'h0008);
        @(posedge clk_i);
        {alu_byte_i, alu_z_we_i, alu_s_we_i} <= 3'h7;
        alu_result_i <= 16'h0100;
        @(posedge clk_i);
        {alu_byte_i, alu_z_we_i, alu_s_we_i} <= 3'h0;
        #1;
        chk("byte zero", processor_flags_o, 16'h0004);
        wr(4'h0, 16'h0240);
        @(posedge clk_i);
        irq_valid_i <= 1'h1;
        irq_level_i <= 3'h5;
        addr_i <= 4'h4;
        rd_i <= 1'h1;
        @(posedge clk_i);
        irq_valid_i <= 1'h0;
        rd_i <= 1'h0;
        #1;
        chk("status", rdata_o, 16'h0001);
        chk("ack", irq_ack_o, 16'h0001);
        chk("after ack", processor_flags_o, 16'h0200);
        $display("core done");
    endtask
    // Final verdict
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // 250 MHz clock
    initial
    begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    // Watchdog
    initial
    begin
        repeat (2000) @(posedge clk_i);
        failures++;
        wrap_up;
    end
    // Main sequence
    initial
    begin
        {wr_i, rd_i, alu_c_we_i, alu_c_i, alu_z_we_i, alu_s_we_i, alu_byte_i} = '0;
        {alu_o_we_i, alu_o_i, sp_we_i, irq_valid_i, trap_exec_i, addr_i} = '0;
        {wdata_i, alu_result_i, sp_wdata_i, trap_vector_i, irq_level_i} = '0;
        srst_i = 1'h1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'h0;
        t_regs;
        t_alu;
        t_irq;
        t_core;
        wrap_up;
    end
endmodule
